// file: core/ccd_consts.svh
`ifndef CCD_CONSTS_SVH
`define CCD_CONSTS_SVH

// ****************************************
// widths
// ****************************************
`define CCD_SAMPLE_W 14
`define CCD_CNT_W 8
`define CCD_EXP_W 4

// ****************************************
// filter, baseline and piso count
// ****************************************
`define CCD_MA_TAPS 8
`define CCD_MA_SHIFT 3
`define CCD_BASE_LEN 32
`define CCD_BASE_SHIFT 5
`define CCD_PISO_NUM 6

// ****************************************
// piso slot positions
// ****************************************
`define CCD_PISO_BASE 0
`define CCD_PISO_FAST 1
`define CCD_PISO_SLOW 2
`define CCD_PISO_FCOR 3
`define CCD_PISO_SCOR 4
`define CCD_PISO_CLASS 5

`endif

// file: core/ccd_pkg.sv
`include "ccd_consts.svh"
package ccd_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_INTEG = 2'b01,
		ST_CORRECT = 2'b10,
		ST_COMPARE = 2'b11
	} state_type;

	typedef struct packed {
		logic [`CCD_SAMPLE_W-1:0] threshold;
		logic [`CCD_CNT_W-1:0] alpha;
		logic [`CCD_CNT_W-1:0] beta;
		logic [`CCD_CNT_W-1:0] delta;
		logic [`CCD_EXP_W-1:0] scaleExp;
	} config_type;
endpackage

// file: core/moving_average.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccd_consts.svh"
module moving_average #(
	parameter int SAMPLE_W = `CCD_SAMPLE_W
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic inValid,
	input wire logic [SAMPLE_W-1:0] inSample,
	output logic outValid,
	output logic [SAMPLE_W-1:0] outAvg
);
	localparam int SUM_W = SAMPLE_W + `CCD_MA_SHIFT;

	logic [SAMPLE_W-1:0] tap_q [`CCD_MA_TAPS];
	logic [SAMPLE_W-1:0] tap_d [`CCD_MA_TAPS];
	logic [SUM_W-1:0] sum_q, sum_d;
	logic valid_q, valid_d;

	always_comb begin
		tap_d = tap_q;
		sum_d = sum_q;
		valid_d = 1'b0;
		if (inValid) begin
			tap_d[0] = inSample;
			for (int i = 1; i < `CCD_MA_TAPS; i++) begin
				tap_d[i] = tap_q[i-1];
			end
			sum_d = sum_q + SUM_W'(inSample)
				- SUM_W'(tap_q[`CCD_MA_TAPS-1]);
			valid_d = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			for (int i = 0; i < `CCD_MA_TAPS; i++) begin
				tap_q[i] <= '0;
			end
			sum_q <= '0;
			valid_q <= 1'b0;
		end else if (clkEn) begin
			tap_q <= tap_d;
			sum_q <= sum_d;
			valid_q <= valid_d;
		end
	end

	assign outValid = valid_q;
	assign outAvg = sum_q[SUM_W-1:`CCD_MA_SHIFT];
endmodule
`default_nettype wire

// file: core/charge_ratio_discriminator.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccd_consts.svh"
module charge_ratio_discriminator #(
	parameter int SAMPLE_W = `CCD_SAMPLE_W,
	parameter int CNT_W = `CCD_CNT_W
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic sampleValid,
	input wire logic [SAMPLE_W-1:0] sample,
	input wire ccd_pkg::config_type cfg,
	input wire logic pisoShift,
	output logic triggerReq,
	output logic resultValid,
	output logic isNeutron,
	output logic [`CCD_PISO_NUM-1:0] pisoBit
);
	import ccd_pkg::*;

	localparam int SUM_W = SAMPLE_W + CNT_W;
	localparam int COR_W = SUM_W + 1;
	localparam int PROD_W = COR_W + CNT_W;
	localparam int BPTR_W = $clog2(`CCD_BASE_LEN);

	// ****************************************
	// elaboration checks
	// ****************************************
	generate
		if (SAMPLE_W != `CCD_SAMPLE_W || CNT_W != `CCD_CNT_W) begin : g_chk
			$error("widths must match the config_type fields");
		end
	endgenerate

	// ****************************************
	// smoothing and threshold
	// ****************************************
	logic maValid;
	logic [SAMPLE_W-1:0] maAvg;

	moving_average #(
		.SAMPLE_W(SAMPLE_W)
	) u_ma (
		.mclk(mclk),
		.reset(reset),
		.clkEn(clkEn),
		.inValid(sampleValid),
		.inSample(sample),
		.outValid(maValid),
		.outAvg(maAvg)
	);

	logic above_q, above_d;
	logic crossPulse;

	// rising crossing only; must fall below to rearm
	always_comb begin
		above_d = above_q;
		if (maValid) begin
			above_d = (maAvg >= cfg.threshold);
		end
	end
	assign crossPulse = maValid && !above_q && (maAvg >= cfg.threshold);

	// ****************************************
	// baseline history
	// ****************************************
	logic [SAMPLE_W-1:0] hist_q [`CCD_BASE_LEN];
	logic [SAMPLE_W-1:0] hist_d [`CCD_BASE_LEN];
	logic [BPTR_W-1:0] hptr_q, hptr_d;
	logic [SUM_W-1:0] baseRun_q, baseRun_d;

	// running 32-sample sum, add new minus oldest
	always_comb begin
		hist_d = hist_q;
		hptr_d = hptr_q;
		baseRun_d = baseRun_q;
		if (sampleValid) begin
			hist_d[hptr_q] = sample;
			hptr_d = hptr_q + 1'b1;
			baseRun_d = baseRun_q + SUM_W'(sample)
				- SUM_W'(hist_q[hptr_q]);
		end
	end

	// ****************************************
	// controller, integrators, correction
	// ****************************************
	state_type state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [SUM_W-1:0] fast_q, fast_d, slow_q, slow_d, base_q, base_d;
	logic fastDone_q, fastDone_d, slowDone_q, slowDone_d;
	logic baseDone_q, baseDone_d;
	logic signed [COR_W-1:0] corF_q, corF_d, corS_q, corS_d;
	logic trig_q, trig_d, rv_q, rv_d, neut_q, neut_d;
	logic [COR_W-1:0] piso_q [`CCD_PISO_NUM];
	logic [COR_W-1:0] piso_d [`CCD_PISO_NUM];
	logic [CNT_W-1:0] nIdx;
	logic [SAMPLE_W-1:0] meanBase;
	logic signed [PROD_W-1:0] rhs;
	logic neutronNow;

	assign nIdx = cnt_q + 1'b1;

	// sum minus count times mean; product kept at full sum width
	function automatic logic signed [COR_W-1:0] pedestal(
		input logic [SUM_W-1:0] total,
		input logic [CNT_W-1:0] count,
		input logic [SAMPLE_W-1:0] mean
	);
		logic [SUM_W-1:0] ped;
		ped = SUM_W'(count) * SUM_W'(mean);
		return $signed({1'b0, total}) - $signed({1'b0, ped});
	endfunction
	// mean baseline is the sum over 32
	assign meanBase = base_q[SAMPLE_W+`CCD_BASE_SHIFT-1:`CCD_BASE_SHIFT];
	// fast term scaled by 2^-scaleExp so delta stays integer
	assign rhs = (PROD_W'($signed({1'b0, cfg.delta})) * PROD_W'(corF_q))
		>>> cfg.scaleExp;
	// neutron when corrected slow reaches delta times fast
	assign neutronNow = PROD_W'(corS_q) >= rhs;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		fast_d = fast_q;
		slow_d = slow_q;
		base_d = base_q;
		fastDone_d = fastDone_q;
		slowDone_d = slowDone_q;
		baseDone_d = baseDone_q;
		corF_d = corF_q;
		corS_d = corS_q;
		trig_d = 1'b0;
		rv_d = 1'b0;
		neut_d = neut_q;
		piso_d = piso_q;
		if (pisoShift) begin
			for (int i = 0; i < `CCD_PISO_NUM; i++) begin
				piso_d[i] = {piso_q[i][COR_W-2:0], 1'b0};
			end
		end
		// fixed sequence: idle, integrate, correct, compare
		unique case (state_q)
			ST_IDLE: begin
				if (crossPulse) begin
					// freeze the 32 samples before the trigger
					base_d = baseRun_q;
					// baseline done at the trigger point
					baseDone_d = 1'b1;
					fast_d = '0;
					slow_d = '0;
					cnt_d = '0;
					fastDone_d = (cfg.alpha == '0);
					slowDone_d = (cfg.beta <= cfg.alpha);
					state_d = ST_INTEG;
				end
			end
			ST_INTEG: begin
				if (sampleValid && !(fastDone_q && slowDone_q)) begin
					cnt_d = nIdx;
					if (nIdx <= cfg.alpha) begin
						fast_d = fast_q + SUM_W'(sample);
					end else if (nIdx <= cfg.beta) begin
						slow_d = slow_q + SUM_W'(sample);
					end
					if (nIdx >= cfg.alpha) begin
						fastDone_d = 1'b1;
					end
					if (nIdx >= cfg.beta) begin
						slowDone_d = 1'b1;
					end
				end
				// match: start correction only when all are done
				if (fastDone_q && slowDone_q && baseDone_q) begin
					state_d = ST_CORRECT;
				end
			end
			ST_CORRECT: begin
				corS_d = pedestal(slow_q, cfg.beta, meanBase);
				corF_d = pedestal(fast_q, cfg.alpha, meanBase);
				state_d = ST_COMPARE;
			end
			ST_COMPARE: begin
				neut_d = neutronNow;
				rv_d = 1'b1;
				// trigger request only for a neutron
				trig_d = neutronNow;
				piso_d[`CCD_PISO_BASE] = COR_W'(base_q);
				piso_d[`CCD_PISO_FAST] = COR_W'(fast_q);
				piso_d[`CCD_PISO_SLOW] = COR_W'(slow_q);
				piso_d[`CCD_PISO_FCOR] = corF_q;
				piso_d[`CCD_PISO_SCOR] = corS_q;
				piso_d[`CCD_PISO_CLASS] = {neutronNow, {(COR_W-1){1'b0}}};
				baseDone_d = 1'b0;
				fastDone_d = 1'b0;
				slowDone_d = 1'b0;
				// back to waiting for the next crossing
				state_d = ST_IDLE;
			end
		endcase
	end

	// ****************************************
	// registers
	// ****************************************
	// cfg is sampled live; the user keeps it still while busy
	always_ff @(posedge mclk) begin
		if (reset) begin
			above_q <= 1'b0;
			for (int i = 0; i < `CCD_BASE_LEN; i++) begin
				hist_q[i] <= '0;
			end
			for (int i = 0; i < `CCD_PISO_NUM; i++) begin
				piso_q[i] <= '0;
			end
			hptr_q <= '0;
			baseRun_q <= '0;
			state_q <= ST_IDLE;
			cnt_q <= '0;
			fast_q <= '0;
			slow_q <= '0;
			base_q <= '0;
			fastDone_q <= 1'b0;
			slowDone_q <= 1'b0;
			baseDone_q <= 1'b0;
			corF_q <= '0;
			corS_q <= '0;
			trig_q <= 1'b0;
			rv_q <= 1'b0;
			neut_q <= 1'b0;
		end else if (clkEn) begin
			above_q <= above_d;
			hist_q <= hist_d;
			hptr_q <= hptr_d;
			baseRun_q <= baseRun_d;
			state_q <= state_d;
			cnt_q <= cnt_d;
			fast_q <= fast_d;
			slow_q <= slow_d;
			base_q <= base_d;
			fastDone_q <= fastDone_d;
			slowDone_q <= slowDone_d;
			baseDone_q <= baseDone_d;
			corF_q <= corF_d;
			corS_q <= corS_d;
			trig_q <= trig_d;
			rv_q <= rv_d;
			neut_q <= neut_d;
			piso_q <= piso_d;
		end
	end

	assign triggerReq = trig_q;
	assign resultValid = rv_q;
	assign isNeutron = neut_q;

	generate
		for (genvar g = 0; g < `CCD_PISO_NUM; g++) begin : g_piso
			assign pisoBit[g] = piso_q[g][COR_W-1];
		end
	endgenerate
endmodule
`default_nettype wire

// file: sim/ccd_checker_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccd_consts.svh"
module ccd_checker #(
	parameter int SAMPLE_W = `CCD_SAMPLE_W,
	parameter int CNT_W = `CCD_CNT_W
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic sampleValid,
	input wire logic [SAMPLE_W-1:0] sample,
	input wire ccd_pkg::config_type cfg,
	input wire logic pisoShift,
	input wire logic triggerReq,
	input wire logic resultValid,
	input wire logic isNeutron,
	input wire logic [`CCD_PISO_NUM-1:0] pisoBit
);
	import ccd_pkg::*;
	// ****************************************
	// output relations
	// ****************************************
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	a_trig_neutron: assert property (triggerReq |-> isNeutron && resultValid)
		else $error("trigger without neutron result");
	a_valid_trig: assert property (resultValid |-> triggerReq == isNeutron)
		else $error("trigger does not follow class");
	a_trig_pulse: assert property (triggerReq && clkEn |=> !triggerReq)
		else $error("trigger longer than one cycle");
	a_result_gap: assert property (resultValid && clkEn |=> !resultValid [*3])
		else $error("results too close together");
	a_class_hold: assert property (!resultValid |-> $stable(isNeutron))
		else $error("class changed without result");
	a_class_piso: assert property (resultValid |->
		pisoBit[`CCD_PISO_CLASS] == isNeutron)
		else $error("class readout bit wrong");
	a_freeze_out: assert property (!clkEn |=> $stable(pisoBit) &&
		$stable(isNeutron) && $stable(triggerReq))
		else $error("outputs moved while frozen");
	a_reset_clear: assert property ($fell(reset) |-> !triggerReq &&
		!resultValid && !isNeutron && pisoBit == '0)
		else $error("outputs not cleared by reset");
	c_neutron: cover property (triggerReq);
	c_gamma: cover property (resultValid && !isNeutron);
	c_freeze: cover property (!clkEn);
endmodule
bind charge_ratio_discriminator ccd_checker #(.SAMPLE_W(SAMPLE_W),
	.CNT_W(CNT_W)) ccd_checker_i (.mclk(mclk), .reset(reset),
	.clkEn(clkEn), .sampleValid(sampleValid), .sample(sample), .cfg(cfg),
	.pisoShift(pisoShift), .triggerReq(triggerReq),
	.resultValid(resultValid), .isNeutron(isNeutron), .pisoBit(pisoBit));
`default_nettype wire

// file: sim/trigger_leaf_model.sv
`timescale 1ns/1ps
`default_nettype none
module trigger_leaf_model (
	input wire logic mclk,
	input wire logic reset,
	input wire logic triggerReq,
	output logic [15:0] count
);
	always_ff @(posedge mclk) begin
		if (reset)
			count <= '0;
		else if (triggerReq)
			count <= count + 16'h0001;
	end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccd_consts.svh"
module tb_top;
	import ccd_pkg::*;
	logic mclk = 0, reset = 1, clkEn = 1, sampleValid = 1, pisoShift = 0;
	logic [`CCD_SAMPLE_W-1:0] sample = '0;
	config_type cfg = '0;
	logic triggerReq, resultValid, isNeutron;
	logic [`CCD_PISO_NUM-1:0] pisoBit;
	logic [15:0] trigCount;
	int numErrors = 0, checksDone = 0, cyc = 0;
	charge_ratio_discriminator charge_ratio_discriminator_i (.mclk(mclk),
		.reset(reset), .clkEn(clkEn), .sampleValid(sampleValid),
		.sample(sample), .cfg(cfg), .pisoShift(pisoShift),
		.triggerReq(triggerReq), .resultValid(resultValid),
		.isNeutron(isNeutron), .pisoBit(pisoBit));
	trigger_leaf_model trigger_leaf_model_i (.mclk(mclk), .reset(reset),
		.triggerReq(triggerReq), .count(trigCount));
	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		checksDone++;
		if (got !== exp) begin
			numErrors++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask
	task automatic stopTest();
		$display("checks %0d mismatches %0d", checksDone, numErrors);
		if (numErrors == 0 && checksDone > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	// flat pulse: fast 4*0x400, slow 16*0x400, baseline holds one 0x400
	// mean baseline 0x20: corrected fast 0xF80, corrected slow 0x3D80
	task automatic run_pulse(logic [7:0] d, logic [3:0] e, bit frz,
		logic expN);
		int n, lo;
		logic [22:0] word [`CCD_PISO_NUM];
		cfg = {14'h0064, 8'h04, 8'h14, d, e};
		sample = '0;
		tick(40);
		sample = 14'h0400;
		n = 0;
		lo = frz ? 29 : 24;
		while (resultValid !== 1'b1 && n < 200) begin
			if (frz)
				clkEn = !(n >= 6 && n < 11);
			tick(1);
			n++;
		end
		chk("latency window", 1, n >= lo && n <= lo + 4);
		chk("trigger", expN, triggerReq);
		chk("class", expN, isNeutron);
		chk("class readout", expN, pisoBit[5]);
		sample = '0;
		tick(1);
		for (int i = 0; i < 23; i++) begin
			for (int k = 0; k < `CCD_PISO_NUM; k++) begin
				word[k] = {word[k][21:0], pisoBit[k]};
			end
			pisoShift = 1;
			tick(1);
		end
		pisoShift = 0;
		chk("base sum", 32'h00000400, word[`CCD_PISO_BASE]);
		chk("fast sum", 32'h00001000, word[`CCD_PISO_FAST]);
		chk("slow sum", 32'h00004000, word[`CCD_PISO_SLOW]);
		chk("fast corrected", 32'h00000F80, word[`CCD_PISO_FCOR]);
		chk("slow corrected", 32'h00003D80, word[`CCD_PISO_SCOR]);
		chk("class word", {expN, 22'h000000}, word[`CCD_PISO_CLASS]);
		$display("done pulse delta %0d exp %0d", d, e);
	endtask
	// raw spike over threshold, filtered mean below it
	task automatic spike_test();
		int n;
		n = 0;
		cfg = {14'h0064, 8'h04, 8'h14, 8'h00, 4'h0};
		tick(40);
		sample = 14'h0258;
		tick(1);
		sample = '0;
		repeat (60) begin
			if (resultValid === 1'b1)
				n++;
			tick(1);
		end
		chk("spike results", 0, n);
		$display("done spike");
	endtask
	task automatic reset_mid();
		int n;
		n = 0;
		tick(40);
		sample = 14'h0400;
		tick(10);
		reset = 1;
		tick(2);
		reset = 0;
		sample = '0;
		repeat (60) begin
			if (resultValid === 1'b1)
				n++;
			tick(1);
		end
		chk("results after reset", 0, n);
		$display("done reset");
	endtask
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			numErrors++;
			stopTest();
		end
	end
	initial begin
		tick(2);
		reset = 0;
		spike_test();
		run_pulse(8'h02, 4'h0, 0, 1);
		run_pulse(8'h08, 4'h0, 0, 0);
		run_pulse(8'h10, 4'h3, 0, 1);
		run_pulse(8'h80, 4'h4, 0, 0);
		run_pulse(8'h00, 4'h0, 1, 1);
		chk("leaf requests", 3, trigCount);
		reset_mid();
		stopTest();
	end
endmodule
`default_nettype wire
